// File: pkg/pad_ctrl_pkg.sv
// Package for the port pad-property control block: register map, reset values, carriers.
// Assumes a 32-bit classic Wishbone slave port and 8-pin ports M and J.
`default_nettype none

package pad_ctrl_pkg;

    // Number of pins on each port.
    localparam int PORT_WIDTH = 8;

    // Register index of the port M open-drain select register (printed offset).
    localparam logic [11:0] OPEN_DRAIN_INDEX    = 12'h256;
    // Register indices chosen for registers without a printed offset.
    localparam logic [11:0] M_POLARITY_INDEX    = 12'h257;
    localparam logic [11:0] M_PULL_ENABLE_INDEX = 12'h258;
    localparam logic [11:0] J_PULL_ENABLE_INDEX = 12'h259;
    localparam logic [11:0] J_POLARITY_INDEX    = 12'h25a;
    localparam logic [11:0] M_STATUS_INDEX      = 12'h25b;
    localparam logic [11:0] J_STATUS_INDEX      = 12'h25c;

    // Byte address is four times the register index.
    localparam int ADDR_SHIFT = 2;

    // Reset values.
    localparam logic [7:0] OPEN_DRAIN_RESET    = 8'h00;
    localparam logic [7:0] M_POLARITY_RESET    = 8'h00;
    localparam logic [7:0] M_PULL_ENABLE_RESET = 8'h00;
    localparam logic [7:0] J_PULL_ENABLE_RESET = 8'hff;
    localparam logic [7:0] J_POLARITY_RESET    = 8'h00;

    // Wishbone request carrier.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [31:0] adr;
        logic [31:0] dat;
    } wb_req_t;

    // Pad control carrier for one port: output enable (low = drive), output
    // level, pull enable and pull direction (1 = pull-up).
    typedef struct packed {
        logic [7:0] oe_n;
        logic [7:0] out;
        logic [7:0] pull_en;
        logic [7:0] pull_up;
    } pad_ctrl_t;

endpackage : pad_ctrl_pkg

`default_nettype wire

// File: rtl/pad_bit_ctrl.sv
// One pin's pad-property logic: output buffer mode and pull device choice.
// Assumes the function owning the pin supplies direction and level each cycle.
`default_nettype none

module pad_bit_ctrl (
    input  wire logic clk_i,          // System clock.
    input  wire logic rst_i,          // Synchronous reset, active high.
    input  wire logic dir_out_i,      // Pin used as output when high.
    input  wire logic data_i,         // Level to drive from the owning function.
    input  wire logic open_drain_i,   // Open-drain mode select.
    input  wire logic pull_en_i,      // Pull device enable.
    input  wire logic polarity_i,     // 1 selects pull-down, 0 pull-up.
    input  wire logic can_rx_i,       // Pin owned as a CAN receive input.
    output logic      oe_n_o,         // Output enable, low while driving.
    output logic      out_o,          // Output level.
    output logic      pull_en_o,      // Pull device active.
    output logic      pull_up_o       // Pull direction, high for pull-up.
);

    ////////////////////////////////////////////////////////////////////////////
    // Output buffer. Registered so the top outputs come from flip-flops.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oe_n_o <= 1'b1;
            out_o  <= 1'b0;
        end else if (!dir_out_i) begin
            // inputs ignore mode. The buffer stays off for an input.
            oe_n_o <= 1'b1;
            out_o  <= 1'b0;
        end else if (open_drain_i) begin
            // open drain. A high is released rather than driven.
            oe_n_o <= data_i;
            out_o  <= 1'b0;
        end else begin
            // push-pull drive. Both levels are driven.
            oe_n_o <= 1'b0;
            out_o  <= data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pull device. Pulls act only on inputs, so an output never fights one.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pull_en_o <= 1'b0;
            pull_up_o <= 1'b1;
        end else if (dir_out_i) begin
            pull_en_o <= 1'b0;
            pull_up_o <= 1'b1;
        end else if (can_rx_i) begin
            // CAN pull-up only. Polarity is ignored on a receive input.
            pull_en_o <= pull_en_i;
            pull_up_o <= 1'b1;
        end else begin
            // polarity one pulls down; zero pulls up.
            pull_en_o <= pull_en_i;
            pull_up_o <= ~polarity_i;
        end
    end

endmodule // pad_bit_ctrl

`default_nettype wire

// File: rtl/port_wb_regs.sv
// Register file for the pad-control block, a classic Wishbone slave.
// Assumes 32-bit data; each 8-bit register sits in the low byte lane.
`default_nettype none

module port_wb_regs
    import pad_ctrl_pkg::*;
(
    input  wire logic                    clk_i,         // System clock.
    input  wire logic                    rst_i,         // Synchronous reset, active high.
    input  wire pad_ctrl_pkg::wb_req_t   req_i,         // Bus request.
    input  wire logic [7:0]              m_status_i,    // Port M live pin state.
    input  wire logic [7:0]              j_status_i,    // Port J live pin state.
    output logic [31:0]                  dat_o,         // Read data.
    output logic                         ack_o,         // Acknowledge.
    output logic [7:0]                   open_drain_o,  // Port M open-drain select.
    output logic [7:0]                   m_polarity_o,  // Port M pull polarity.
    output logic [7:0]                   m_pull_en_o,   // Port M pull enable.
    output logic [7:0]                   j_pull_en_o,   // Port J pull enable.
    output logic [7:0]                   j_polarity_o   // Port J pull polarity.
);

    logic [11:0] index;     // Register index from the byte address.
    logic        strobe;    // New request, not a cycle in which ack is high.
    logic        wr_lane;   // Write with the low byte lane enabled.

    assign index   = req_i.adr[11+ADDR_SHIFT:ADDR_SHIFT];
    assign strobe  = req_i.cyc && req_i.stb && !ack_o;
    assign wr_lane = strobe && req_i.we && req_i.sel[0];

    ////////////////////////////////////////////////////////////////////////////
    // Acknowledge one cycle after the request; dropped the cycle after.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= strobe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // writable at any time. Writes land on the edge that raises ack.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            open_drain_o <= OPEN_DRAIN_RESET;
            m_polarity_o <= M_POLARITY_RESET;
            m_pull_en_o  <= M_PULL_ENABLE_RESET;
            j_pull_en_o  <= J_PULL_ENABLE_RESET;
            j_polarity_o <= J_POLARITY_RESET;
        end else if (wr_lane) begin
            if (index == OPEN_DRAIN_INDEX) begin
                open_drain_o <= req_i.dat[7:0];
            end else if (index == M_POLARITY_INDEX) begin
                m_polarity_o <= req_i.dat[7:0];
            end else if (index == M_PULL_ENABLE_INDEX) begin
                m_pull_en_o <= req_i.dat[7:0];
            end else if (index == J_PULL_ENABLE_INDEX) begin
                j_pull_en_o <= req_i.dat[7:0];
            end else if (index == J_POLARITY_INDEX) begin
                j_polarity_o <= req_i.dat[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, registered with ack. Unmapped addresses read zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (strobe && !req_i.we) begin
            if (index == OPEN_DRAIN_INDEX) begin
                dat_o <= {24'h00_0000, open_drain_o};
            end else if (index == M_POLARITY_INDEX) begin
                dat_o <= {24'h00_0000, m_polarity_o};
            end else if (index == M_PULL_ENABLE_INDEX) begin
                dat_o <= {24'h00_0000, m_pull_en_o};
            end else if (index == J_PULL_ENABLE_INDEX) begin
                dat_o <= {24'h00_0000, j_pull_en_o};
            end else if (index == J_POLARITY_INDEX) begin
                dat_o <= {24'h00_0000, j_polarity_o};
            end else if (index == M_STATUS_INDEX) begin
                dat_o <= {24'h00_0000, m_status_i};
            end else if (index == J_STATUS_INDEX) begin
                dat_o <= {24'h00_0000, j_status_i};
            end else begin
                dat_o <= 32'h0000_0000;
            end
        end else begin
            dat_o <= 32'h0000_0000;
        end
    end

endmodule // port_wb_regs

`default_nettype wire

// File: rtl/port_pad_control.sv
// Top of the port pad-property control block for ports M and J.
// Assumes pin directions and levels come from the owning function each cycle,
// already prioritised, and that the pads take enable, level and pull controls.
//
// How it works
// - Controls pin properties per owning function.
// - Polarity one pulls down on GPIO inputs.
// - Polarity zero pulls up, GPIO or CAN.
// - CAN receive input never pulls down.
// - Wired-or set: drive low only.
// - Wired-or clear: drive both levels.
// - Open-drain applies whatever function drives.
// - Wired-or ignored on input pins.
// - Port J input pull follows enable bit.
// - Port J output pins get no pull.
// - Port J pull enables set after reset.
// - Registers readable and writable any time.
// - Port J polarity one pulls down.
//
// Added by the designer: register access over Wishbone.
`default_nettype none

module port_pad_control
    import pad_ctrl_pkg::*;
(
    input  wire logic                      clk_i,          // System clock, 125 MHz.
    input  wire logic                      rst_i,          // Synchronous reset, active high.
    input  wire pad_ctrl_pkg::wb_req_t     wb_req_i,       // Wishbone request.
    output logic [31:0]                    wb_dat_o,       // Wishbone read data.
    output logic                           wb_ack_o,       // Wishbone acknowledge.
    input  wire logic [7:0]                m_gpio_dir_i,   // Port M GPIO direction, 1 = out.
    input  wire logic [7:0]                m_gpio_out_i,   // Port M GPIO output level.
    input  wire logic [7:0]                m_periph_own_i, // Port M pin owned by a peripheral.
    input  wire logic [7:0]                m_periph_dir_i, // Port M peripheral direction.
    input  wire logic [7:0]                m_periph_out_i, // Port M peripheral output level.
    input  wire logic [7:0]                can_receive_input_i, // Port M pin is CAN receive.
    input  wire logic [7:0]                m_pin_i,        // Port M pad input levels.
    input  wire logic [7:0]                j_dir_i,        // Port J direction, 1 = out.
    input  wire logic [7:0]                j_out_i,        // Port J output level.
    input  wire logic [7:0]                j_pin_i,        // Port J pad input levels.
    output pad_ctrl_pkg::pad_ctrl_t        m_pad_o,        // Port M pad controls.
    output pad_ctrl_pkg::pad_ctrl_t        j_pad_o         // Port J pad controls.
);

    ////////////////////////////////////////////////////////////////////////////
    // Register file.

    logic [7:0] open_drain;   // Port M open-drain select.
    logic [7:0] m_polarity;   // Port M pull polarity.
    logic [7:0] m_pull_en;    // Port M pull enable.
    logic [7:0] j_pull_en;    // Port J pull enable.
    logic [7:0] j_polarity;   // Port J pull polarity.
    logic [7:0] m_dir;        // Port M effective direction.
    logic [7:0] m_data;       // Port M effective output level.
    logic [7:0] m_can;        // Port M CAN receive ownership.

    port_wb_regs u_regs (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .req_i        (wb_req_i),
        .m_status_i   (m_pin_i),
        .j_status_i   (j_pin_i),
        .dat_o        (wb_dat_o),
        .ack_o        (wb_ack_o),
        .open_drain_o (open_drain),
        .m_polarity_o (m_polarity),
        .m_pull_en_o  (m_pull_en),
        .j_pull_en_o  (j_pull_en),
        .j_polarity_o (j_polarity)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Function selection on port M. A peripheral that owns a pin wins over
    // GPIO; the pad settings then apply the same way to either source, except polarity on a CAN receive pin.

    assign m_dir  = (m_periph_own_i & m_periph_dir_i) | (~m_periph_own_i & m_gpio_dir_i);
    assign m_data = (m_periph_own_i & m_periph_out_i) | (~m_periph_own_i & m_gpio_out_i);
    // A CAN receive pin is an input of the CAN function only.
    assign m_can  = can_receive_input_i & m_periph_own_i;

    ////////////////////////////////////////////////////////////////////////////
    // Per-pin pad logic. Port J has no wired-or control, so it is push-pull.

    genvar g;
    generate
        for (g = 0; g < PORT_WIDTH; g++) begin : g_pin
            pad_bit_ctrl u_m (
                .clk_i        (clk_i),
                .rst_i        (rst_i),
                .dir_out_i    (m_dir[g]),
                .data_i       (m_data[g]),
                .open_drain_i (open_drain[g]),
                .pull_en_i    (m_pull_en[g]),
                .polarity_i   (m_polarity[g]),
                .can_rx_i     (m_can[g]),
                .oe_n_o       (m_pad_o.oe_n[g]),
                .out_o        (m_pad_o.out[g]),
                .pull_en_o    (m_pad_o.pull_en[g]),
                .pull_up_o    (m_pad_o.pull_up[g])
            );

            pad_bit_ctrl u_j (
                .clk_i        (clk_i),
                .rst_i        (rst_i),
                .dir_out_i    (j_dir_i[g]),
                .data_i       (j_out_i[g]),
                .open_drain_i (1'b0),
                .pull_en_i    (j_pull_en[g]),
                .polarity_i   (j_polarity[g]),
                .can_rx_i     (1'b0),
                .oe_n_o       (j_pad_o.oe_n[g]),
                .out_o        (j_pad_o.out[g]),
                .pull_en_o    (j_pad_o.pull_en[g]),
                .pull_up_o    (j_pad_o.pull_up[g])
            );
        end
    endgenerate

endmodule // port_pad_control

`default_nettype wire

// File: verif/port_pad_control_properties.sv
// Checker for the pad control block, bound to its top module.
// Assumes the package is compiled first and one clock domain.
`default_nettype none

module port_pad_control_properties
    import pad_ctrl_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire pad_ctrl_pkg::wb_req_t  wb_req_i,
    input  wire logic                   wb_ack_o,
    input  wire logic [7:0]             m_gpio_dir_i,
    input  wire logic [7:0]             m_gpio_out_i,
    input  wire logic [7:0]             m_periph_own_i,
    input  wire logic [7:0]             m_periph_dir_i,
    input  wire logic [7:0]             m_periph_out_i,
    input  wire logic [7:0]             can_receive_input_i,
    input  wire logic [7:0]             j_dir_i,
    input  wire logic [7:0]             j_out_i,
    input  wire pad_ctrl_pkg::pad_ctrl_t m_pad_o,
    input  wire pad_ctrl_pkg::pad_ctrl_t j_pad_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] dm;   // Effective port M direction.
    logic [7:0] dd;   // Effective port M output level.
    logic [7:0] jpe;  // Shadow of the port J pull enables.
    assign dm = (m_periph_own_i & m_periph_dir_i) | (~m_periph_own_i & m_gpio_dir_i);
    assign dd = (m_periph_own_i & m_periph_out_i) | (~m_periph_own_i & m_gpio_out_i);
    // The shadow follows taken writes, so pull checks need no bus decode.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            jpe <= J_PULL_ENABLE_RESET;
        end else if (wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !wb_ack_o && wb_req_i.sel[0]
                     && wb_req_i.adr[13:2] == J_PULL_ENABLE_INDEX) begin
            jpe <= wb_req_i.dat[7:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_one_cycle: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> ack_once)
        else $error("ack not a single pulse");
    // An ack only ever answers a request that was taken on the edge before.
    a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_req_i.cyc && wb_req_i.stb && !wb_ack_o))
        else $error("ack without a request");
    a_j_pull_follow: assert property (!rst_i |=> j_pad_o.pull_en == ($past(jpe) & ~$past(j_dir_i)))
        else $error("port J pull enable wrong");
    a_j_push_pull: assert property (!rst_i |=> j_pad_o.oe_n == ~$past(j_dir_i))
        else $error("port J drive enable wrong");
    a_m_input_free: assert property (!rst_i |=> (m_pad_o.oe_n | $past(dm)) == 8'hff)
        else $error("port M input pin driven");
    a_m_drive_low: assert property (!rst_i |=>
        (~m_pad_o.oe_n & ~m_pad_o.out & $past(dm)) == ($past(dm) & ~$past(dd)))
        else $error("port M low level wrong");
    a_m_no_false_high: assert property (!rst_i |=> (~m_pad_o.oe_n & m_pad_o.out & ~$past(dm & dd)) == 8'h00)
        else $error("port M driven high wrongly");
    a_m_out_no_pull: assert property (!rst_i |=> (m_pad_o.pull_en & $past(dm)) == 8'h00)
        else $error("pull on port M output");
    a_can_no_down: assert property (!rst_i |=> (m_pad_o.pull_en & ~m_pad_o.pull_up
        & $past(m_periph_own_i & can_receive_input_i & ~dm)) == 8'h00)
        else $error("pull-down on CAN input");
endmodule // port_pad_control_properties

bind port_pad_control port_pad_control_properties port_pad_control_properties_inst (
    .clk_i, .rst_i, .wb_req_i, .wb_ack_o, .m_gpio_dir_i, .m_gpio_out_i, .m_periph_own_i,
    .m_periph_dir_i, .m_periph_out_i, .can_receive_input_i, .j_dir_i, .j_out_i, .m_pad_o, .j_pad_o);

`default_nettype wire

// File: verif/pin_owner_model.sv
// Peripherals that claim port M pins: none, a serial output, or CAN receive.
// Assumes the bench picks the mode; outputs change one edge later.
`default_nettype none

module pin_owner_model (
    input  wire logic       clk_i,   // System clock.
    input  wire logic [1:0] mode_i,  // 0 none, 1 serial output, 2 CAN receive.
    output logic [7:0]      own_o,   // Pins claimed.
    output logic [7:0]      dir_o,   // Peripheral direction.
    output logic [7:0]      out_o,   // Peripheral level.
    output logic [7:0]      can_o    // CAN receive pins.
);
    timeunit 1ns;
    timeprecision 1ps;
    // Registered like a real peripheral, so ownership never glitches mid-cycle.
    always_ff @(posedge clk_i) begin
        own_o <= (mode_i != 2'h0) ? 8'hff : 8'h00;
        dir_o <= (mode_i == 2'h1) ? 8'hff : 8'h00;
        out_o <= (mode_i == 2'h1) ? 8'h5a : 8'h00;
        can_o <= (mode_i == 2'h2) ? 8'hff : 8'h00;
    end
endmodule // pin_owner_model

`default_nettype wire

// File: verif/port_pad_control_tb_top.sv
// Self-checking bench for the pad control block.
// Assumes the checker is bound and the partner model owns peripheral pins.
`default_nettype none

module port_pad_control_tb_top
    import pad_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, ack;
    wb_req_t req;
    logic [31:0] dat;
    logic [7:0] gdir, gout, jdir, jout, own, pdir, pout, can, q;
    logic [1:0] mode;
    pad_ctrl_t mpad, jpad;
    int num_errors = 0;
    int check_count = 0;
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    port_pad_control port_pad_control_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat),
        .wb_ack_o(ack), .m_gpio_dir_i(gdir), .m_gpio_out_i(gout), .m_periph_own_i(own), .m_periph_dir_i(pdir),
        .m_periph_out_i(pout), .can_receive_input_i(can), .m_pin_i(8'h3c), .j_dir_i(jdir), .j_out_i(jout),
        .j_pin_i(8'hc3), .m_pad_o(mpad), .j_pad_o(jpad));
    pin_owner_model pin_owner_model_inst (.clk_i(clk_i), .mode_i(mode), .own_o(own), .dir_o(pdir),
        .out_o(pout), .can_o(can));
    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One classic cycle. The request stands until ack is sampled high at a rising
    // edge; read data is taken at that same edge and the request is released there.
    // No cycle count is assumed: a hang is left to the watchdog.
    task automatic wb(input logic we, input logic [11:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: {18'h0, idx, 2'h0}, dat: {24'h0, d}};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = dat[7:0];
        req <= '0;
    endtask
    task automatic rd(input logic [11:0] idx, input logic [7:0] exp, input string what);
        wb(1'b0, idx, 8'h00);
        chk(what, q, exp);
    endtask
    task automatic settle;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic t_regs;
        logic [11:0] idx [5] = '{OPEN_DRAIN_INDEX, M_POLARITY_INDEX, M_PULL_ENABLE_INDEX,
                                 J_PULL_ENABLE_INDEX, J_POLARITY_INDEX};
        chk("j pull pads", jpad.pull_en, 8'hff);
        rd(OPEN_DRAIN_INDEX, 8'h00, "od reset");
        rd(J_PULL_ENABLE_INDEX, 8'hff, "j pull reset");
        rd(12'h300, 8'h00, "unmapped");
        rd(M_STATUS_INDEX, 8'h3c, "m status");
        rd(J_STATUS_INDEX, 8'hc3, "j status");
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, idx[i], 8'ha5 ^ 8'(i));
            rd(idx[i], 8'ha5 ^ 8'(i), "reg rw");
        end
    endtask
    task automatic t_drive;
        @(posedge clk_i);
        gdir <= 8'hf0;
        gout <= 8'h3c;
        wb(1'b1, OPEN_DRAIN_INDEX, 8'h00);
        settle();
        chk("pp oe_n", mpad.oe_n, 8'h0f);
        chk("pp out", mpad.out, 8'h30);
        wb(1'b1, OPEN_DRAIN_INDEX, 8'hff);
        settle();
        chk("od oe_n", mpad.oe_n, 8'h3f);
        chk("od out", mpad.out, 8'h00);
        @(posedge clk_i);
        mode <= 2'h1;
        settle();
        chk("per od oe_n", mpad.oe_n, 8'h5a);
        wb(1'b1, OPEN_DRAIN_INDEX, 8'h00);
        settle();
        chk("per pp out", mpad.out & ~mpad.oe_n, 8'h5a);
    endtask
    task automatic t_mpull;
        @(posedge clk_i);
        mode <= 2'h0;
        gdir <= 8'h00;
        wb(1'b1, M_PULL_ENABLE_INDEX, 8'hff);
        wb(1'b1, M_POLARITY_INDEX, 8'h0f);
        settle();
        chk("m pull en", mpad.pull_en, 8'hff);
        chk("m pull up", mpad.pull_up, 8'hf0);
        @(posedge clk_i);
        mode <= 2'h2;
        settle();
        chk("can down", mpad.pull_en & ~mpad.pull_up, 8'h00);
        wb(1'b1, M_POLARITY_INDEX, 8'h00);
        settle();
        chk("can up", mpad.pull_en & mpad.pull_up, 8'hff);
    endtask
    task automatic t_jport;
        wb(1'b1, J_PULL_ENABLE_INDEX, 8'h3c);
        wb(1'b1, J_POLARITY_INDEX, 8'h0f);
        settle();
        chk("j pull en", jpad.pull_en, 8'h3c);
        chk("j pull up", jpad.pull_up & jpad.pull_en, 8'h30);
        @(posedge clk_i);
        jdir <= 8'hf0;
        jout <= 8'ha5;
        settle();
        chk("j out pull", jpad.pull_en, 8'h0c);
        chk("j out lvl", jpad.out & ~jpad.oe_n, 8'ha0);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        rst_i = 1'b1;
        req = '0;
        {gdir, gout, jdir, jout, mode} = '0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        t_regs();
        t_drive();
        t_mpull();
        t_jport();
        results();
    end
    // A hang counts as a mismatch and ends the run the normal way.
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        results();
    end
endmodule // port_pad_control_tb_top

`default_nettype wire
